/* pkg/ien_pkg.sv */
// Package for the interrupt-enable block of the two-wire bus controller.
// Assumes a 32-bit AXI4-Lite register bus and one clock domain.
package ien_pkg;

  // ******************************************
  // Register map
  // ******************************************
  localparam logic [11:0] IEN_ADDR_ENABLE_SET = 12'h008; // Enable set and read
  localparam logic [11:0] IEN_ADDR_ENABLE_CLEAR = 12'h00C; // Enable clear, write only
  localparam logic [11:0] IEN_ADDR_FLAGS = 12'h004; // Flag view, read only

  // ******************************************
  // Field positions
  // ******************************************
  localparam int IEN_BIT_MST_PENDING = 0;
  localparam int IEN_BIT_MST_ARB_LOST = 4;
  localparam int IEN_BIT_MST_SS_ERR = 6;
  localparam int IEN_BIT_SLV_PENDING = 8;
  localparam int IEN_BIT_SLV_NO_STRETCH = 11;
  localparam int IEN_BIT_SLV_DESELECT = 15;
  localparam int IEN_BIT_MON_READY = 16;
  localparam int IEN_BIT_MON_OVERRUN = 17;
  localparam int IEN_BIT_MON_IDLE = 19;
  localparam int IEN_BIT_EVENT_TIMEOUT = 24;
  localparam int IEN_BIT_CLK_LOW_TIMEOUT = 25;

  // Positions that hold an enable
  localparam logic [31:0] IEN_IMPL_MASK = 32'h030B_8951;
  // Value after reset: all disabled
  localparam logic [31:0] IEN_RESET_VALUE = 32'h0000_0000;

  // AXI responses
  localparam logic [1:0] IEN_RESP_OKAY = 2'h0;
  localparam logic [1:0] IEN_RESP_SLVERR = 2'h2;

  // Write side states
  typedef enum logic [1:0] {
    IEN_W_IDLE = 2'b00,
    IEN_W_RESP = 2'b01
  } ien_wstate_t;

  // Write request carried to the enable register
  typedef struct packed {
    logic set_strobe;
    logic clr_strobe;
    logic [31:0] data;
  } ien_wreq_t;

endpackage

/* hdl/ien_enable_reg.sv */
// Enable register bank with set and clear strobes.
// Assumes strobes come from the bus slave on the same clock.
`timescale 1ns/10ps
`default_nettype none
module ien_enable_reg
  import ien_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire ien_wreq_t wreq,
  input wire logic [31:0] flags,
  output logic [31:0] enables,
  output logic irq
);

  // ******************************************
  // State
  // ******************************************
  typedef struct packed {
    logic [31:0] en; // Enable bits
    logic irq; // Request line
  } ien_reg_state_t;

  ien_reg_state_t state; // Registered copy
  ien_reg_state_t next_state; // Next copy

  // Clear overrides set in the same cycle, masked to real positions
  always_comb
  begin
    next_state = state;
    if (wreq.set_strobe)
    begin
      // Ones set, zeros keep
      next_state.en = state.en | (wreq.data & IEN_IMPL_MASK);
    end
    if (wreq.clr_strobe)
    begin
      // Ones clear
      next_state.en = state.en & ~(wreq.data & IEN_IMPL_MASK);
    end
    // Request held while any enabled flag stands
    next_state.irq = |(flags & state.en & IEN_IMPL_MASK);
  end

  // Register the state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state.en <= IEN_RESET_VALUE;
      state.irq <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign enables = state.en;
  assign irq = state.irq;

endmodule // ien_enable_reg
`default_nettype wire

/* hdl/ien_top.sv */
// Interrupt enable set/clear block with AXI4-Lite slave.
// Assumes status flags arrive on aclk from the controller core.
`timescale 1ns/10ps
`default_nettype none
module ien_top
  import ien_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] status_flags,
  output logic irq
);

  // ******************************************
  // State
  // ******************************************
  typedef struct packed {
    ien_wstate_t wst; // Write phase
    logic aw_held; // Address captured
    logic [11:0] awaddr; // Captured address
    logic w_held; // Data captured
    logic [31:0] wdata; // Captured data
    logic [3:0] wstrb; // Captured strobes
    logic awready; // Address ready
    logic wready; // Data ready
    logic bvalid; // Response valid
    logic [1:0] bresp; // Response code
    logic arready; // Read address ready
    logic rvalid; // Read data valid
    logic [31:0] rdata; // Read data
    logic [1:0] rresp; // Read code
    ien_wreq_t wreq; // Strobe to enable bank
  } ien_top_state_t;

  ien_top_state_t state; // Registered copy
  ien_top_state_t next_state; // Next copy
  logic [31:0] enables; // Enable bits from bank
  logic bank_irq; // Request from bank

  // ******************************************
  // Enable bank
  // ******************************************
  ien_enable_reg u_bank (
    .aclk(aclk),
    .aresetn(aresetn),
    .wreq(state.wreq),
    .flags(status_flags),
    .enables(enables),
    .irq(bank_irq)
  );

  // ******************************************
  // Bus slave
  // ******************************************
  // Address and data taken in either order, one write at a time
  always_comb
  begin
    next_state = state;
    next_state.wreq = '0;
    // Address capture
    if (state.awready && s_axi_awvalid)
    begin
      next_state.aw_held = 1'b1;
      next_state.awaddr = s_axi_awaddr;
      next_state.awready = 1'b0;
    end
    // Data capture
    if (state.wready && s_axi_wvalid)
    begin
      next_state.w_held = 1'b1;
      next_state.wdata = s_axi_wdata;
      next_state.wstrb = s_axi_wstrb;
      next_state.wready = 1'b0;
    end
    case (state.wst)
      IEN_W_IDLE:
      begin
        // Both halves in: act and answer
        if (state.aw_held && state.w_held)
        begin
          next_state.bvalid = 1'b1;
          next_state.bresp = IEN_RESP_OKAY;
          next_state.wst = IEN_W_RESP;
          // Partial strobes act only on written lanes
          next_state.wreq.data = state.wdata & {{8{state.wstrb[3]}}, {8{state.wstrb[2]}},
            {8{state.wstrb[1]}}, {8{state.wstrb[0]}}};
          if (state.awaddr[11:2] == IEN_ADDR_ENABLE_SET[11:2])
          begin
            next_state.wreq.set_strobe = 1'b1;
          end
          else if (state.awaddr[11:2] == IEN_ADDR_ENABLE_CLEAR[11:2])
          begin
            next_state.wreq.clr_strobe = 1'b1;
          end
          else
          begin
            // Flag view is read only; others unmapped
            next_state.bresp = IEN_RESP_SLVERR;
          end
        end
      end
      IEN_W_RESP:
      begin
        // Hold response until taken, then reopen
        if (s_axi_bready)
        begin
          next_state.bvalid = 1'b0;
          next_state.aw_held = 1'b0;
          next_state.w_held = 1'b0;
          next_state.awready = 1'b1;
          next_state.wready = 1'b1;
          next_state.wst = IEN_W_IDLE;
        end
      end
      default:
      begin
        next_state.wst = IEN_W_IDLE;
      end
    endcase
    // Read path: one read at a time
    if (state.arready && s_axi_arvalid)
    begin
      next_state.arready = 1'b0;
      next_state.rvalid = 1'b1;
      next_state.rresp = IEN_RESP_OKAY;
      if (s_axi_araddr[11:2] == IEN_ADDR_ENABLE_SET[11:2])
      begin
        // Reserved bits read zero
        next_state.rdata = enables & IEN_IMPL_MASK;
      end
      else if (s_axi_araddr[11:2] == IEN_ADDR_FLAGS[11:2])
      begin
        next_state.rdata = status_flags;
      end
      else if (s_axi_araddr[11:2] == IEN_ADDR_ENABLE_CLEAR[11:2])
      begin
        // Write only: reads zero
        next_state.rdata = 32'h0000_0000;
      end
      else
      begin
        next_state.rdata = 32'h0000_0000;
        next_state.rresp = IEN_RESP_SLVERR;
      end
    end
    else if (state.rvalid && s_axi_rready)
    begin
      next_state.rvalid = 1'b0;
      next_state.arready = 1'b1;
    end
  end

  // Register the state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= '0;
      state.wst <= IEN_W_IDLE;
      state.awready <= 1'b1;
      state.wready <= 1'b1;
      state.arready <= 1'b1;
    end
    else
    begin
      state <= next_state;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = state.awready;
  assign s_axi_wready = state.wready;
  assign s_axi_bvalid = state.bvalid;
  assign s_axi_bresp = state.bresp;
  assign s_axi_arready = state.arready;
  assign s_axi_rvalid = state.rvalid;
  assign s_axi_rdata = state.rdata;
  assign s_axi_rresp = state.rresp;
  assign irq = bank_irq;

  // ******************************************
  // Checks
  // ******************************************
  property p_set_write;
    @(posedge aclk) disable iff (!aresetn)
    state.wreq.set_strobe |=>
      ((enables & $past(state.wreq.data) & IEN_IMPL_MASK) == ($past(state.wreq.data) & IEN_IMPL_MASK));
  endproperty
  a_set_write: assert property (p_set_write) else $error("set write missed");

  property p_set_keeps;
    @(posedge aclk) disable iff (!aresetn)
    (state.wreq.set_strobe && !state.wreq.clr_strobe) |=> ((enables & $past(enables)) == $past(enables));
  endproperty
  a_set_keeps: assert property (p_set_keeps) else $error("set cleared a bit");

  property p_clr_write;
    @(posedge aclk) disable iff (!aresetn)
    state.wreq.clr_strobe |=> ((enables & $past(state.wreq.data)) == 32'h0000_0000);
  endproperty
  a_clr_write: assert property (p_clr_write) else $error("clear write missed");

  property p_reserved_zero;
    @(posedge aclk) disable iff (!aresetn)
    (enables & ~IEN_IMPL_MASK) == 32'h0000_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved enable set");

  property p_read_enables;
    @(posedge aclk) disable iff (!aresetn)
    (state.arready && s_axi_arvalid && s_axi_araddr == IEN_ADDR_ENABLE_SET) |=>
      (s_axi_rvalid && s_axi_rdata == $past(enables));
  endproperty
  a_read_enables: assert property (p_read_enables) else $error("read data wrong");

  property p_irq_gate;
    @(posedge aclk) disable iff (!aresetn)
    1'b1 |=> (irq == |($past(status_flags) & $past(enables)));
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq mismatch");

  property p_reset_off;
    @(posedge aclk)
    !aresetn |=> (enables == IEN_RESET_VALUE);
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("enable after reset");

  property p_bvalid_hold;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped");

  // ******************************************
  // Enable bit and bus checks
  // ******************************************
  // Zero set write must leave every enable as it was
  property p_zero_keeps;
    @(posedge aclk) disable iff (!aresetn)
    (state.wreq.set_strobe && (state.wreq.data & IEN_IMPL_MASK) == 32'h0000_0000) |=>
      (enables == $past(enables));
  endproperty
  a_zero_keeps: assert property (p_zero_keeps) else $error("zero write changed enables");

  // Clear touches only the written ones
  property p_clr_keeps;
    @(posedge aclk) disable iff (!aresetn)
    state.wreq.clr_strobe |=>
      ((enables & ~$past(state.wreq.data)) == ($past(enables) & ~$past(state.wreq.data)));
  endproperty
  a_clr_keeps: assert property (p_clr_keeps) else $error("clear hit other enables");

  // Refused write leaves the bank alone
  property p_refused_no_effect;
    @(posedge aclk) disable iff (!aresetn)
    ($rose(s_axi_bvalid) && s_axi_bresp == IEN_RESP_SLVERR) |=> (enables == $past(enables));
  endproperty
  a_refused_no_effect: assert property (p_refused_no_effect) else $error("refused write acted");

  // Flags only at unsupported positions never raise the request
  property p_reserved_irq;
    @(posedge aclk) disable iff (!aresetn)
    ((status_flags & IEN_IMPL_MASK) == 32'h0000_0000) |=> !irq;
  endproperty
  a_reserved_irq: assert property (p_reserved_irq) else $error("reserved flag raised irq");

  // Both halves held: answer on the next edge
  property p_write_answer;
    @(posedge aclk) disable iff (!aresetn)
    (state.wst == IEN_W_IDLE && state.aw_held && state.w_held) |=> s_axi_bvalid;
  endproperty
  a_write_answer: assert property (p_write_answer) else $error("write answer late");

  // Read address taken: data next edge, address closed
  property p_read_answer;
    @(posedge aclk) disable iff (!aresetn)
    (s_axi_arready && s_axi_arvalid) |=> (s_axi_rvalid && !s_axi_arready);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("read answer late");

  // Six of the eleven per-source enables checked to land one edge after the strobe
  property p_mst_pending_on;
    @(posedge aclk) disable iff (!aresetn)
    (state.wreq.set_strobe && state.wreq.data[IEN_BIT_MST_PENDING]) |=> enables[IEN_BIT_MST_PENDING];
  endproperty
  a_mst_pending_on: assert property (p_mst_pending_on) else $error("master pending enable not set");

  property p_arb_lost_on;
    @(posedge aclk) disable iff (!aresetn)
    (state.wreq.set_strobe && state.wreq.data[IEN_BIT_MST_ARB_LOST]) |=> enables[IEN_BIT_MST_ARB_LOST];
  endproperty
  a_arb_lost_on: assert property (p_arb_lost_on) else $error("arbitration loss enable not set");

  property p_deselect_on;
    @(posedge aclk) disable iff (!aresetn)
    (state.wreq.set_strobe && state.wreq.data[IEN_BIT_SLV_DESELECT]) |=> enables[IEN_BIT_SLV_DESELECT];
  endproperty
  a_deselect_on: assert property (p_deselect_on) else $error("deselect enable not set");

  property p_mon_ready_on;
    @(posedge aclk) disable iff (!aresetn)
    (state.wreq.set_strobe && state.wreq.data[IEN_BIT_MON_READY]) |=> enables[IEN_BIT_MON_READY];
  endproperty
  a_mon_ready_on: assert property (p_mon_ready_on) else $error("monitor ready enable not set");

  property p_mon_idle_on;
    @(posedge aclk) disable iff (!aresetn)
    (state.wreq.set_strobe && state.wreq.data[IEN_BIT_MON_IDLE]) |=> enables[IEN_BIT_MON_IDLE];
  endproperty
  a_mon_idle_on: assert property (p_mon_idle_on) else $error("monitor idle enable not set");

  property p_clk_low_on;
    @(posedge aclk) disable iff (!aresetn)
    (state.wreq.set_strobe && state.wreq.data[IEN_BIT_CLK_LOW_TIMEOUT]) |=> enables[IEN_BIT_CLK_LOW_TIMEOUT];
  endproperty
  a_clk_low_on: assert property (p_clk_low_on) else $error("clock low enable not set");

  c_set: cover property (@(posedge aclk) disable iff (!aresetn) state.wreq.set_strobe);
  c_clr: cover property (@(posedge aclk) disable iff (!aresetn) state.wreq.clr_strobe);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  c_refused: cover property (@(posedge aclk) disable iff (!aresetn) s_axi_bvalid && s_axi_bresp == IEN_RESP_SLVERR);

endmodule // ien_top
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the interrupt-enable block, register bus and request.
// Assumes ien_pkg and ien_top are compiled first; assertions live in the design.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import ien_pkg::*;

  // ************************************
  // Signals, rows and counters
  // ************************************
  typedef struct packed {
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [1:0] resp;
    logic [31:0] rd;
  } ien_tb_row_t; // One write, then the expected enable readback

  logic aclk = 1'b0; // 200 MHz bench clock
  logic aresetn = 1'b0; // Held low for the first 12 cycles
  logic [11:0] awaddr = 12'h000;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = 32'h0000_0000;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [11:0] araddr = 12'h000;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic [31:0] flags = 32'h0000_0000; // Status flag levels
  logic irq;
  logic [31:0] rd;
  logic [1:0] rs;
  int miscompares = 0;
  int cmp_count = 0;

  // Ordinary cases: each bit set alone, then zero, clear, set all, refused
  // Software side writes zeros to reserved positions in every row
  ien_tb_row_t rows [17] = '{
    '{12'h008, 32'h0000_0001, 2'h0, 32'h0000_0001},
    '{12'h008, 32'h0000_0010, 2'h0, 32'h0000_0011},
    '{12'h008, 32'h0000_0040, 2'h0, 32'h0000_0051},
    '{12'h008, 32'h0000_0100, 2'h0, 32'h0000_0151},
    '{12'h008, 32'h0000_0800, 2'h0, 32'h0000_0951},
    '{12'h008, 32'h0000_8000, 2'h0, 32'h0000_8951},
    '{12'h008, 32'h0001_0000, 2'h0, 32'h0001_8951},
    '{12'h008, 32'h0002_0000, 2'h0, 32'h0003_8951},
    '{12'h008, 32'h0008_0000, 2'h0, 32'h000B_8951},
    '{12'h008, 32'h0100_0000, 2'h0, 32'h010B_8951},
    '{12'h008, 32'h0200_0000, 2'h0, 32'h030B_8951},
    '{12'h008, 32'h0000_0000, 2'h0, 32'h030B_8951},
    '{12'h00C, 32'h030B_8951, 2'h0, 32'h0000_0000},
    '{12'h008, 32'h030B_8951, 2'h0, 32'h030B_8951},
    '{12'h00C, 32'h0000_0011, 2'h0, 32'h030B_8940},
    '{12'h004, 32'h0000_0001, 2'h2, 32'h030B_8940},
    '{12'h01C, 32'h0000_0001, 2'h2, 32'h030B_8940}
  };

  // Clock: invert each half period
  always #2.5 aclk = ~aclk;

  ien_top DUT (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .status_flags(flags), .irq(irq)
  );

  // ************************************
  // Tasks
  // ************************************
  // Closing report; the only place the run ends
  task automatic print_verdict;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Four-state compare, so an unknown never matches
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bounded wait ran out: count it and close
  task automatic hang(input string nm);
    miscompares++;
    $display("MISMATCH %s expected answer seen none", nm);
    print_verdict();
  endtask

  // Write: address and data offered together, each released when taken
  task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
    bit ok;
    ok = 0;
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (int n = 0; n < 64 && !ok; n++)
    begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        r = bresp;
        bready <= 1'b0;
        ok = 1;
      end
    end
    if (!ok) hang("write response");
  endtask

  // Read: rready held until rvalid is seen
  task automatic bus_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    bit ok;
    ok = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (int n = 0; n < 64 && !ok; n++)
    begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        ok = 1;
      end
    end
    if (!ok) hang("read data");
  endtask

  // Request lags flags by one registered stage; sample after it lands
  task automatic irq_after(input logic [31:0] f, input logic e);
    @(posedge aclk);
    flags <= f;
    repeat (2) @(posedge aclk);
    #1;
    chk("irq", {31'h0, e}, {31'h0, irq});
  endtask

  // ************************************
  // Main sequence
  // ************************************
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    bus_rd(IEN_ADDR_ENABLE_SET, rd, rs);
    chk("reset enables", IEN_RESET_VALUE, rd);
    chk("reset irq", 32'h0, {31'h0, irq});
    $display("Test reset done");
    foreach (rows[i])
    begin
      bus_wr(rows[i].addr, rows[i].wdata, rs);
      chk("write response", {30'h0, rows[i].resp}, {30'h0, rs});
      bus_rd(IEN_ADDR_ENABLE_SET, rd, rs);
      chk("enable readback", rows[i].rd, rd);
    end
    $display("Test table rows done");
    // Unmapped read is refused with zero data
    bus_rd(12'h01C, rd, rs);
    chk("unmapped read response", {30'h0, IEN_RESP_SLVERR}, {30'h0, rs});
    chk("unmapped read data", 32'h0, rd);
    $display("Test unmapped read done");
    // Enables now 0x030B8940: bits 0 and 4 off, bit 1 reserved
    irq_after(32'h0000_0013, 1'b0);
    irq_after(32'h0000_0040, 1'b1);
    irq_after(32'h0000_0000, 1'b0);
    irq_after(32'h0000_0001, 1'b0);
    bus_wr(IEN_ADDR_ENABLE_SET, 32'h0000_0001, rs);
    irq_after(32'h0000_0001, 1'b1);
    bus_wr(IEN_ADDR_ENABLE_CLEAR, 32'h0000_0001, rs);
    irq_after(32'h0000_0001, 1'b0);
    $display("Test request gating done");
    // Flag view and write-only clear register read back plainly
    bus_rd(IEN_ADDR_FLAGS, rd, rs);
    chk("flag view data", 32'h0000_0001, rd);
    chk("flag view response", {30'h0, IEN_RESP_OKAY}, {30'h0, rs});
    bus_rd(IEN_ADDR_ENABLE_CLEAR, rd, rs);
    chk("clear read data", 32'h0, rd);
    chk("clear read response", {30'h0, IEN_RESP_OKAY}, {30'h0, rs});
    $display("Test plain reads done");
    // Second reset in mid-run with a flag standing
    bus_wr(IEN_ADDR_ENABLE_SET, 32'h0300_0000, rs);
    flags <= 32'h0100_0000;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    bus_rd(IEN_ADDR_ENABLE_SET, rd, rs);
    chk("enables after reset", IEN_RESET_VALUE, rd);
    chk("irq after reset", 32'h0, {31'h0, irq});
    $display("Test mid-run reset done");
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
